// file: hw/sqp_pkg.sv
//==============================================================================
// Constants for the shared-PLL reset controller
//==============================================================================
// Purpose: Constants, types and helpers for the shared PLL reset controller.
// Assumes: 200 MHz system clock and one controller for the whole channel group.
// Notes:   Rules of the arrangement follow.

package sqp_pkg;

	//==========================================================================
	// Timing
	//==========================================================================
	localparam int CLK_PERIOD_PS = 5000;
	localparam int PS_PER_NS     = 1000;
	localparam int NS_PER_US     = 1000;

	// Least time a full reset is held after the reference is healthy again
	localparam int RST_HOLD_NS   = 200;
	// Longest wait for a PLL to report lock after its reset ends
	localparam int LOCK_WAIT_US  = 1000;

	function automatic int sqp_cyc_up(input int ps);
		int c;
		c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int sqp_cyc_down(input int ps);
		int c;
		c = ps / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int RST_HOLD_CYC  = sqp_cyc_up(RST_HOLD_NS * PS_PER_NS);
	localparam int LOCK_WAIT_CYC = sqp_cyc_down(LOCK_WAIT_US * NS_PER_US * PS_PER_NS);

	//==========================================================================
	// Static strap values driven toward the device
	//==========================================================================
	localparam logic [1:0] TXCLK_SEL_CHANNEL_PLL  = 2'h0;
	localparam logic       SRC_SEL_SHARED_OFF     = 1'h0;
	localparam logic       TX_RATE_SEL_UNUSED     = 1'h0;
	localparam logic       REF_OK_TIED            = 1'h1;

	//==========================================================================
	// Reset sequence states
	//==========================================================================
	typedef enum logic [1:0]
	{
		SQP_RESET,
		SQP_WAIT_LOCK,
		SQP_RUN
	} sqp_seq_t;

endpackage

// file: hw/sqp_ref_if.sv
//==============================================================================
// Reference health carrier between monitor and sequencer
//==============================================================================
// Purpose: Carries one reference's health and full-reset request.
// Assumes: Both ends run on clk_sys.
// Notes:   The monitor drives; the sequencer only reads.

interface sqp_ref_if;
	logic ref_ok;
	logic full_reset;

	modport mon
	(
		output ref_ok,
		output full_reset
	);

	modport ctl
	(
		input ref_ok,
		input full_reset
	);
endinterface

// file: hw/sqp_ref_mon.sv
//==============================================================================
// Reference clock health monitor
//==============================================================================
// Purpose: Watches one reference clock and asks for a full reset on change or loss.
// Assumes: ref_stable and ref_change come from pins; force_req is on clk_sys.
// Notes:   Reset is held while the fault lasts and HOLD_CYC cycles after it ends.

module sqp_ref_mon
#(
	parameter int HOLD_CYC = sqp_pkg::RST_HOLD_CYC
)
(
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic ref_stable,
	input  wire logic ref_change,
	input  wire logic force_req,
	sqp_ref_if.mon    mon
);

	localparam int CW = $clog2(HOLD_CYC + 1);
	localparam logic [CW-1:0] HOLD_LOAD = CW'(HOLD_CYC);
	localparam logic [CW-1:0] CNT_ZERO  = '0;

	generate
		if (HOLD_CYC < 1)
		begin : g_chk
			$error("sqp_ref_mon: HOLD_CYC must be at least 1");
		end
	endgenerate

	logic          stable_s1_r;
	logic          stable_s2_r;
	logic          change_s1_r;
	logic          change_s2_r;
	logic [CW-1:0] hold_cnt_r;
	logic          full_reset_r;
	logic          fault;

	//==========================================================================
	// Pin synchronisers
	//==========================================================================
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			stable_s1_r <= 1'b0;
			stable_s2_r <= 1'b0;
			change_s1_r <= 1'b0;
			change_s2_r <= 1'b0;
		end
		else
		begin
			stable_s1_r <= ref_stable;
			stable_s2_r <= stable_s1_r;
			change_s1_r <= ref_change;
			change_s2_r <= change_s1_r;
		end
	end

	assign fault = !stable_s2_r || change_s2_r || force_req;

	//==========================================================================
	// Full reset stretcher
	//==========================================================================
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			hold_cnt_r   <= HOLD_LOAD;
			full_reset_r <= 1'b1;
		end
		else if (fault)
		begin
			hold_cnt_r   <= HOLD_LOAD;
			full_reset_r <= 1'b1;
		end
		else if (hold_cnt_r != CNT_ZERO)
		begin
			hold_cnt_r   <= hold_cnt_r - 1'b1;
			full_reset_r <= 1'b1;
		end
		else
		begin
			full_reset_r <= 1'b0;
		end
	end

	assign mon.ref_ok     = stable_s2_r;
	assign mon.full_reset = full_reset_r;

endmodule

// file: hw/sqp_host.sv
//==============================================================================
// Shared and channel PLL reset controller
//==============================================================================
// Purpose: Drives a group of SDI transceiver control instances: resets,
//          lock and reference status, and static straps.
// Assumes: Receivers use the shared group PLL, transmitters their own PLL.
// Notes:   Lock and reference pins are synchronised before use.

module sqp_host
#(
	parameter int NUM_CH        = 4,
	parameter int MASTER        = 0,
	parameter int HOLD_CYC      = sqp_pkg::RST_HOLD_CYC,
	parameter int LOCK_WAIT_CYC = sqp_pkg::LOCK_WAIT_CYC
)
(
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire logic                shared_ref_stable,
	input  wire logic                shared_ref_change,
	input  wire logic [NUM_CH-1:0]   ch_ref_stable,
	input  wire logic [NUM_CH-1:0]   ch_ref_change,
	input  wire logic                user_rx_reset_req,
	input  wire logic [NUM_CH-1:0]   user_tx_reset_req,
	input  wire logic                shared_group_pll_lock,
	input  wire logic [NUM_CH-1:0]   channel_pll_lock,
	input  wire logic                dev_master_shared_pll_reset,
	input  wire logic [NUM_CH-1:0]   dev_channel_pll_reset,
	output logic                     shared_group_pll_reset,
	output logic [NUM_CH-1:0]        channel_pll_reset,
	output logic [2*NUM_CH-1:0]      channel_tx_clk_sel,
	output logic [NUM_CH-1:0]        dev_rx_full_reset,
	output logic [NUM_CH-1:0]        dev_tx_full_reset,
	output logic [NUM_CH-1:0]        dev_rx_pll_locked,
	output logic [NUM_CH-1:0]        dev_tx_pll_locked,
	output logic [NUM_CH-1:0]        dev_rx_refclk_ok,
	output logic [NUM_CH-1:0]        dev_tx_refclk_ok,
	output logic [NUM_CH-1:0]        dev_tx_rate_sel,
	output logic [NUM_CH-1:0]        dev_tx_src_sel_low_shared,
	output logic [NUM_CH-1:0]        dev_tx_src_sel_high_shared,
	output logic                     rx_ready,
	output logic [NUM_CH-1:0]        tx_ready
);

	localparam int LW = $clog2(LOCK_WAIT_CYC + 1);
	localparam logic [LW-1:0] WAIT_LOAD = LW'(LOCK_WAIT_CYC);
	localparam logic [LW-1:0] WAIT_ZERO = '0;

	//==========================================================================
	// Elaboration checks
	//==========================================================================
	generate
		if (NUM_CH < 1 || MASTER < 0 || MASTER >= NUM_CH)
		begin : g_chk_ch
			$error("sqp_host: MASTER must index one of NUM_CH channels");
		end
		if (LOCK_WAIT_CYC < 1 || HOLD_CYC < 1)
		begin : g_chk_cnt
			$error("sqp_host: counts must be at least 1");
		end
	endgenerate

	//==========================================================================
	// Lock synchronisers
	//==========================================================================
	logic              qlock_s1_r;
	logic              qlock_s2_r;
	logic [NUM_CH-1:0] clock_s1_r;
	logic [NUM_CH-1:0] clock_s2_r;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			qlock_s1_r <= 1'b0;
			qlock_s2_r <= 1'b0;
			clock_s1_r <= '0;
			clock_s2_r <= '0;
		end
		else
		begin
			qlock_s1_r <= shared_group_pll_lock;
			qlock_s2_r <= qlock_s1_r;
			clock_s1_r <= channel_pll_lock;
			clock_s2_r <= clock_s1_r;
		end
	end

	//==========================================================================
	// Shared reference: monitor and receive sequence
	//==========================================================================
	sqp_ref_if         q_ref ();
	logic              rx_retry_r;
	sqp_pkg::sqp_seq_t rx_state_r;
	logic [LW-1:0]     rx_wait_r;

	sqp_ref_mon
	#(
		.HOLD_CYC   (HOLD_CYC)
	)
	u_shared_mon
	(
		.clk_sys    (clk_sys),
		.rst        (rst),
		.ref_stable (shared_ref_stable),
		.ref_change (shared_ref_change),
		.force_req  (user_rx_reset_req | rx_retry_r),
		.mon        (q_ref.mon)
	);

	// Retry the full reset if the shared PLL never locks
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			rx_state_r <= sqp_pkg::SQP_RESET;
			rx_wait_r  <= WAIT_LOAD;
			rx_retry_r <= 1'b0;
		end
		else
		begin
			rx_retry_r <= 1'b0;
			if (q_ref.full_reset)
			begin
				rx_state_r <= sqp_pkg::SQP_RESET;
				rx_wait_r  <= WAIT_LOAD;
			end
			else
			begin
				unique case (rx_state_r)
					sqp_pkg::SQP_RESET:
					begin
						rx_state_r <= sqp_pkg::SQP_WAIT_LOCK;
						rx_wait_r  <= WAIT_LOAD;
					end
					sqp_pkg::SQP_WAIT_LOCK:
					begin
						if (qlock_s2_r)
						begin
							rx_state_r <= sqp_pkg::SQP_RUN;
						end
						else if (rx_wait_r == WAIT_ZERO)
						begin
							rx_retry_r <= 1'b1;
							rx_state_r <= sqp_pkg::SQP_RESET;
						end
						else
						begin
							rx_wait_r <= rx_wait_r - 1'b1;
						end
					end
					sqp_pkg::SQP_RUN:
					begin
						if (!qlock_s2_r)
						begin
							rx_state_r <= sqp_pkg::SQP_WAIT_LOCK;
							rx_wait_r  <= WAIT_LOAD;
						end
					end
				endcase
			end
		end
	end

	assign rx_ready = (rx_state_r == sqp_pkg::SQP_RUN);

	//==========================================================================
	// Per-channel reference monitors and transmit sequences
	//==========================================================================
	logic [NUM_CH-1:0] ch_full_reset;
	logic [NUM_CH-1:0] ch_ref_ok;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++)
		begin : g_ch
			sqp_ref_if         c_ref ();
			logic              tx_retry_r;
			sqp_pkg::sqp_seq_t tx_state_r;
			logic [LW-1:0]     tx_wait_r;

			sqp_ref_mon
			#(
				.HOLD_CYC   (HOLD_CYC)
			)
			u_ch_mon
			(
				.clk_sys    (clk_sys),
				.rst        (rst),
				.ref_stable (ch_ref_stable[gi]),
				.ref_change (ch_ref_change[gi]),
				.force_req  (user_tx_reset_req[gi] | tx_retry_r),
				.mon        (c_ref.mon)
			);

			assign ch_full_reset[gi] = c_ref.full_reset;
			assign ch_ref_ok[gi]     = c_ref.ref_ok;

			// Waits only on this channel's own PLL lock
			always_ff @(posedge clk_sys)
			begin
				if (rst)
				begin
					tx_state_r <= sqp_pkg::SQP_RESET;
					tx_wait_r  <= WAIT_LOAD;
					tx_retry_r <= 1'b0;
				end
				else
				begin
					tx_retry_r <= 1'b0;
					if (c_ref.full_reset)
					begin
						tx_state_r <= sqp_pkg::SQP_RESET;
						tx_wait_r  <= WAIT_LOAD;
					end
					else
					begin
						unique case (tx_state_r)
							sqp_pkg::SQP_RESET:
							begin
								tx_state_r <= sqp_pkg::SQP_WAIT_LOCK;
								tx_wait_r  <= WAIT_LOAD;
							end
							sqp_pkg::SQP_WAIT_LOCK:
							begin
								if (clock_s2_r[gi])
								begin
									tx_state_r <= sqp_pkg::SQP_RUN;
								end
								else if (tx_wait_r == WAIT_ZERO)
								begin
									tx_retry_r <= 1'b1;
									tx_state_r <= sqp_pkg::SQP_RESET;
								end
								else
								begin
									tx_wait_r <= tx_wait_r - 1'b1;
								end
							end
							sqp_pkg::SQP_RUN:
							begin
								if (!clock_s2_r[gi])
								begin
									tx_state_r <= sqp_pkg::SQP_WAIT_LOCK;
									tx_wait_r  <= WAIT_LOAD;
								end
							end
						endcase
					end
				end
			end

			assign tx_ready[gi] = (tx_state_r == sqp_pkg::SQP_RUN);
		end
	endgenerate

	//==========================================================================
	// PLL reset routing
	//==========================================================================
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			shared_group_pll_reset <= 1'b1;
			channel_pll_reset      <= '1;
		end
		else
		begin
			shared_group_pll_reset <= dev_master_shared_pll_reset;
			channel_pll_reset      <= dev_channel_pll_reset;
		end
	end

	//==========================================================================
	// Status and resets toward each instance
	//==========================================================================
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			dev_rx_full_reset <= '1;
			dev_tx_full_reset <= '1;
			dev_rx_pll_locked <= '0;
			dev_tx_pll_locked <= '0;
			dev_rx_refclk_ok  <= '0;
			dev_tx_refclk_ok  <= '0;
		end
		else
		begin
			dev_rx_full_reset <= {NUM_CH{q_ref.full_reset}};
			dev_tx_full_reset <= ch_full_reset;
			dev_rx_pll_locked <= {NUM_CH{qlock_s2_r}};
			dev_tx_pll_locked <= clock_s2_r;
			dev_tx_refclk_ok  <= ch_ref_ok;
			for (int i = 0; i < NUM_CH; i++)
			begin
				dev_rx_refclk_ok[i] <= (i == MASTER) ? q_ref.ref_ok
					: sqp_pkg::REF_OK_TIED;
			end
		end
	end

	//==========================================================================
	// Static straps
	//==========================================================================
	always_ff @(posedge clk_sys)
	begin
		channel_tx_clk_sel         <= {NUM_CH{sqp_pkg::TXCLK_SEL_CHANNEL_PLL}};
		dev_tx_src_sel_low_shared  <= {NUM_CH{sqp_pkg::SRC_SEL_SHARED_OFF}};
		dev_tx_src_sel_high_shared <= {NUM_CH{sqp_pkg::SRC_SEL_SHARED_OFF}};
		dev_tx_rate_sel            <= {NUM_CH{sqp_pkg::TX_RATE_SEL_UNUSED}};
	end

endmodule

// file: tb/sqp_host_sva.sv
// Purpose: Port checks for the PLL reset controller.
// Assumes: One clock domain.
// Notes:   Bounds follow the two-flop synchronisers.
module sqp_host_sva
#(
	parameter int NUM_CH = 4,
	parameter int MASTER = 0
)
(
	input wire logic                clk_sys,
	input wire logic                rst,
	input wire logic                shared_ref_stable,
	input wire logic                shared_ref_change,
	input wire logic [NUM_CH-1:0]   ch_ref_stable,
	input wire logic                shared_group_pll_lock,
	input wire logic [NUM_CH-1:0]   channel_pll_lock,
	input wire logic                dev_master_shared_pll_reset,
	input wire logic [NUM_CH-1:0]   dev_channel_pll_reset,
	input wire logic                shared_group_pll_reset,
	input wire logic [NUM_CH-1:0]   channel_pll_reset,
	input wire logic [2*NUM_CH-1:0] channel_tx_clk_sel,
	input wire logic [NUM_CH-1:0]   dev_rx_full_reset,
	input wire logic [NUM_CH-1:0]   dev_tx_full_reset,
	input wire logic [NUM_CH-1:0]   dev_rx_pll_locked,
	input wire logic [NUM_CH-1:0]   dev_tx_pll_locked,
	input wire logic [NUM_CH-1:0]   dev_rx_refclk_ok,
	input wire logic [NUM_CH-1:0]   dev_tx_rate_sel,
	input wire logic [NUM_CH-1:0]   dev_tx_src_sel_low_shared,
	input wire logic [NUM_CH-1:0]   dev_tx_src_sel_high_shared,
	input wire logic [NUM_CH-1:0]   tx_ready
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	//==========================================================================
	// Sequences
	//==========================================================================
	sequence s_rx_fault;
		$fell(shared_ref_stable) || $rose(shared_ref_change);
	endsequence
	sequence s_rx_held;
		(dev_rx_full_reset == {NUM_CH{1'b1}}) [*4];
	endsequence

	//==========================================================================
	// Assertions
	//==========================================================================
	chk_rx_fault_rst: assert property (s_rx_fault |-> ##[1:4] (dev_rx_full_reset == {NUM_CH{1'b1}}))
		else $error("receive full reset missing after shared fault");
	chk_rx_rst_hold: assert property ($rose(dev_rx_full_reset[0]) |-> s_rx_held)
		else $error("receive full reset too short or split");
	chk_tx_fault_rst: assert property ($fell(ch_ref_stable[0]) |-> ##[1:4] dev_tx_full_reset[0])
		else $error("transmit full reset missing after channel fault");
	chk_shared_rst_route: assert property (!rst |=> shared_group_pll_reset == $past(dev_master_shared_pll_reset))
		else $error("shared PLL reset not routed from master");
	chk_ch_rst_route: assert property (!rst |=> channel_pll_reset == $past(dev_channel_pll_reset))
		else $error("channel PLL reset not routed");
	chk_clk_sel_tie: assert property (channel_tx_clk_sel == '0)
		else $error("transmit clock selector not tied to channel PLL");
	chk_src_sel_zero: assert property ((dev_tx_src_sel_low_shared | dev_tx_src_sel_high_shared | dev_tx_rate_sel) == '0)
		else $error("source or rate select not low");
	chk_rx_lock_path: assert property ($rose(shared_group_pll_lock) |-> ##[1:3] (dev_rx_pll_locked == {NUM_CH{1'b1}}))
		else $error("shared lock not passed to every receiver");
	chk_tx_lock_own: assert property ((!channel_pll_lock[0]) [*4] |-> !dev_tx_pll_locked[0])
		else $error("transmit lock shows without own PLL lock");
	chk_ready_locked: assert property ($rose(tx_ready[0]) |-> dev_tx_pll_locked[0] && !dev_tx_full_reset[0])
		else $error("transmit ready without lock");
	chk_ref_ok_tied: assert property (!rst |=> (dev_rx_refclk_ok | NUM_CH'(1 << MASTER)) == {NUM_CH{1'b1}})
		else $error("non-master receive reference ok not high");
endmodule

bind sqp_host sqp_host_sva #(.NUM_CH(NUM_CH), .MASTER(MASTER)) i_sqp_host_sva
(
	.clk_sys(clk_sys), .rst(rst), .shared_ref_stable(shared_ref_stable),
	.shared_ref_change(shared_ref_change), .ch_ref_stable(ch_ref_stable),
	.shared_group_pll_lock(shared_group_pll_lock), .channel_pll_lock(channel_pll_lock),
	.dev_master_shared_pll_reset(dev_master_shared_pll_reset),
	.dev_channel_pll_reset(dev_channel_pll_reset), .shared_group_pll_reset(shared_group_pll_reset),
	.channel_pll_reset(channel_pll_reset), .channel_tx_clk_sel(channel_tx_clk_sel),
	.dev_rx_full_reset(dev_rx_full_reset), .dev_tx_full_reset(dev_tx_full_reset),
	.dev_rx_pll_locked(dev_rx_pll_locked), .dev_tx_pll_locked(dev_tx_pll_locked),
	.dev_rx_refclk_ok(dev_rx_refclk_ok), .dev_tx_rate_sel(dev_tx_rate_sel),
	.dev_tx_src_sel_low_shared(dev_tx_src_sel_low_shared),
	.dev_tx_src_sel_high_shared(dev_tx_src_sel_high_shared), .tx_ready(tx_ready)
);

// file: tb/sqp_dev_model.sv
// Purpose: Behavioural channel group: control instances and PLLs.
// Assumes: PLLs lock LOCK_DLY cycles after their reset drops.
// Notes:   lock_block holds a channel PLL unlocked.
module sqp_dev_model
#(
	parameter int NUM_CH   = 4,
	parameter int MASTER   = 0,
	parameter int LOCK_DLY = 8
)
(
	input  wire logic              clk_sys,
	input  wire logic              shared_pll_rst,
	input  wire logic [NUM_CH-1:0] ch_pll_rst,
	input  wire logic [NUM_CH-1:0] rx_full_reset,
	input  wire logic [NUM_CH-1:0] tx_full_reset,
	input  wire logic [NUM_CH-1:0] tx_pll_locked,
	input  wire logic [NUM_CH-1:0] tx_rate_sel,
	input  wire logic [NUM_CH-1:0] src_low,
	input  wire logic [NUM_CH-1:0] src_high,
	input  wire logic [NUM_CH-1:0] lock_block,
	input  wire logic              sd_mode,
	output logic                   master_pll_rst,
	output logic [NUM_CH-1:0]      own_pll_rst,
	output logic                   shared_lock,
	output logic [NUM_CH-1:0]      ch_lock,
	output logic [NUM_CH-1:0]      shared_picked,
	output logic [NUM_CH-1:0]      tx_done,
	output logic                   slew_slow
);
	timeunit 1ns;
	timeprecision 100ps;

	int sh_cnt;
	int ch_cnt [NUM_CH];

	always_ff @(posedge clk_sys)
	begin
		master_pll_rst <= rx_full_reset[MASTER];
		own_pll_rst    <= tx_full_reset;
		sh_cnt         <= shared_pll_rst ? 0 : sh_cnt + int'(sh_cnt < LOCK_DLY);
		for (int i = 0; i < NUM_CH; i++)
			ch_cnt[i] <= ch_pll_rst[i] ? 0 : ch_cnt[i] + int'(ch_cnt[i] < LOCK_DLY);
	end

	always_comb
	begin
		shared_lock = sh_cnt >= LOCK_DLY;
		for (int i = 0; i < NUM_CH; i++)
		begin
			ch_lock[i]       = ch_cnt[i] >= LOCK_DLY && !lock_block[i];
			tx_done[i]       = !tx_full_reset[i] && tx_pll_locked[i];
			shared_picked[i] = tx_rate_sel[i] ? src_high[i] : src_low[i];
		end
		slew_slow = sd_mode;
	end
endmodule

// file: tb/sqp_host_tb.sv
// Purpose: Self-checking bench for the PLL reset controller.
// Assumes: Short hold and lock-wait counts.
// Notes:   Expectations come from fault masks kept as N-bit vectors.
module sqp_host_tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int N    = 4;
	localparam int HOLD = 4;
	localparam logic [N-1:0] ALL1 = '1;

	logic clk_sys, rst, shared_ref_stable, shared_ref_change, user_rx_reset_req, sd_mode;
	logic [N-1:0] ch_ref_stable, ch_ref_change, user_tx_reset_req, lock_block;
	logic shared_group_pll_lock, dev_master_shared_pll_reset, shared_group_pll_reset, rx_ready;
	logic [N-1:0] channel_pll_lock, dev_channel_pll_reset, channel_pll_reset, tx_ready;
	logic [N-1:0] dev_rx_full_reset, dev_tx_full_reset, dev_rx_pll_locked, dev_tx_pll_locked;
	logic [N-1:0] dev_rx_refclk_ok, dev_tx_refclk_ok, dev_tx_rate_sel, src_lo, src_hi, picked;
	logic [2*N-1:0] channel_tx_clk_sel;
	logic [N-1:0] tx_done;
	logic slew;
	int err_total;
	int tests_run;

	sqp_host #(.NUM_CH(N), .MASTER(0), .HOLD_CYC(HOLD), .LOCK_WAIT_CYC(50)) i_sqp_host
	(
		.clk_sys(clk_sys), .rst(rst), .shared_ref_stable(shared_ref_stable),
		.shared_ref_change(shared_ref_change), .ch_ref_stable(ch_ref_stable),
		.ch_ref_change(ch_ref_change), .user_rx_reset_req(user_rx_reset_req),
		.user_tx_reset_req(user_tx_reset_req), .shared_group_pll_lock(shared_group_pll_lock),
		.channel_pll_lock(channel_pll_lock), .dev_master_shared_pll_reset(dev_master_shared_pll_reset),
		.dev_channel_pll_reset(dev_channel_pll_reset), .shared_group_pll_reset(shared_group_pll_reset),
		.channel_pll_reset(channel_pll_reset), .channel_tx_clk_sel(channel_tx_clk_sel),
		.dev_rx_full_reset(dev_rx_full_reset), .dev_tx_full_reset(dev_tx_full_reset),
		.dev_rx_pll_locked(dev_rx_pll_locked), .dev_tx_pll_locked(dev_tx_pll_locked),
		.dev_rx_refclk_ok(dev_rx_refclk_ok), .dev_tx_refclk_ok(dev_tx_refclk_ok),
		.dev_tx_rate_sel(dev_tx_rate_sel), .dev_tx_src_sel_low_shared(src_lo),
		.dev_tx_src_sel_high_shared(src_hi), .rx_ready(rx_ready), .tx_ready(tx_ready)
	);

	sqp_dev_model #(.NUM_CH(N), .MASTER(0)) i_sqp_dev_model
	(
		.clk_sys(clk_sys), .shared_pll_rst(shared_group_pll_reset), .ch_pll_rst(channel_pll_reset),
		.rx_full_reset(dev_rx_full_reset), .tx_full_reset(dev_tx_full_reset),
		.tx_pll_locked(dev_tx_pll_locked), .tx_rate_sel(dev_tx_rate_sel), .src_low(src_lo),
		.src_high(src_hi), .lock_block(lock_block), .sd_mode(sd_mode),
		.master_pll_rst(dev_master_shared_pll_reset), .own_pll_rst(dev_channel_pll_reset),
		.shared_lock(shared_group_pll_lock), .ch_lock(channel_pll_lock),
		.shared_picked(picked), .tx_done(tx_done), .slew_slow(slew)
	);

	//==========================================================================
	// Tasks
	//==========================================================================
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("Counts: %0d checks, %0d mismatches", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wait_ready;
		int k;
		k = 0;
		while (!(rx_ready === 1'b1 && tx_ready === '1) && k < 1000)
		begin
			@(posedge clk_sys);
			k++;
		end
		chk(k < 1000, 1'b1);
	endtask

	// Fault on the shared reference (ch < 0) or one channel, on stable or change pin
	task automatic run_fault(input int ch, input bit by_change);
		int n;
		logic [N-1:0] m;
		n = $urandom_range(8, 4);
		m = (ch < 0) ? '0 : N'(1 << ch);
		@(posedge clk_sys);
		if (ch < 0 && by_change) shared_ref_change <= 1'b1;
		else if (ch < 0) shared_ref_stable <= 1'b0;
		else if (by_change) ch_ref_change[ch] <= 1'b1;
		else ch_ref_stable[ch] <= 1'b0;
		repeat (n) @(posedge clk_sys);
		shared_ref_change <= 1'b0;
		shared_ref_stable <= 1'b1;
		ch_ref_change     <= '0;
		ch_ref_stable     <= '1;
		repeat (3) @(posedge clk_sys);
		chk(dev_rx_full_reset, (ch < 0) ? ALL1 : '0);
		chk(dev_rx_refclk_ok, {ALL1[N-1:1], 1'(ch >= 0 || by_change)});
		chk(dev_tx_refclk_ok, by_change ? ALL1 : N'(~m));
		chk(dev_tx_full_reset, m);
		chk(shared_group_pll_reset, ch < 0);
		chk(channel_pll_reset, m);
		repeat (HOLD + 6) @(posedge clk_sys);
		chk({dev_rx_full_reset, dev_tx_full_reset}, '0);
		wait_ready();
		$display("fault test ch=%0d change=%0d done", ch, by_change);
	endtask

	//==========================================================================
	// Clock, watchdog and main sequence
	//==========================================================================
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		stop_test();
	end

	initial
	begin
		logic [N-1:0] m;
		err_total = 0;
		tests_run = 0;
		rst = 1'b1;
		shared_ref_stable = 1'b1;
		shared_ref_change = 1'b0;
		ch_ref_stable = '1;
		ch_ref_change = '0;
		user_rx_reset_req = 1'b0;
		user_tx_reset_req = '0;
		lock_block = '0;
		sd_mode = 1'b0;
		void'($urandom(55941));
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		wait_ready();
		chk(channel_tx_clk_sel, '0);
		chk({src_lo, src_hi, picked}, '0);
		chk(dev_tx_rate_sel, '0);
		chk(dev_rx_refclk_ok, ALL1);
		chk(dev_tx_refclk_ok, ALL1);
		chk(dev_rx_pll_locked, ALL1);
		chk(tx_done, ALL1);
		chk(slew, 1'b0);
		$display("bring-up test done");
		for (int c = -1; c < N; c++)
			for (int b = 0; b < 2; b++)
				run_fault(c, b[0]);
		m = N'($urandom_range(15, 1));
		user_rx_reset_req <= 1'b1;
		user_tx_reset_req <= m;
		sd_mode <= 1'b1;
		@(posedge clk_sys);
		user_rx_reset_req <= 1'b0;
		user_tx_reset_req <= '0;
		repeat (3) @(posedge clk_sys);
		chk(dev_rx_full_reset, ALL1);
		chk(dev_tx_full_reset, m);
		chk(slew, 1'b1);
		wait_ready();
		$display("user reset test done");
		m = N'($urandom_range(15, 1));
		lock_block <= m;
		repeat (6) @(posedge clk_sys);
		chk(dev_tx_pll_locked, N'(~m));
		chk(dev_rx_pll_locked, ALL1);
		chk(tx_ready, N'(~m));
		chk(tx_done, N'(~m));
		lock_block <= '0;
		wait_ready();
		$display("lock test done");
		stop_test();
	end
endmodule
